// ==== pkg/swb_pkg.sv ====
// constants, encodings and slot timing for the byte command engine
package swb_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_BYTE = 8'hA5;
    localparam logic [7:0] CMD_READ_BYTE  = 8'h96;

    // ------------------------------------------------------------
    // clocks and bit counts
    // ------------------------------------------------------------
    localparam int         MCLK_PERIOD_NS = 40;
    localparam int         LCLK_PERIOD_NS = 125;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    localparam logic [7:0] ALL_ONES       = 8'hFF;
    localparam logic [7:0] BYTE_CLEAR     = 8'h00;
    localparam int         CNT_W          = 10;

    // ------------------------------------------------------------
    // slot times in ns, standard and overdrive speed
    // ------------------------------------------------------------
    localparam int SLOT_STD_NS   = 70000;
    localparam int SLOT_OD_NS    = 10000;
    localparam int LOW0_STD_NS   = 60000;
    localparam int LOW0_OD_NS    = 8000;
    localparam int LOW1_STD_NS   = 6000;
    localparam int LOW1_OD_NS    = 1000;
    localparam int SAMPLE_STD_NS = 15000;
    localparam int SAMPLE_OD_NS  = 2000;
    localparam int APU_NS        = 500;

    // ------------------------------------------------------------
    // link clock cycle counts (least times round up, sample rounds down)
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] SLOT_STD_CYC   =
        CNT_W'((SLOT_STD_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SLOT_OD_CYC    =
        CNT_W'((SLOT_OD_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LOW0_STD_CYC   =
        CNT_W'((LOW0_STD_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LOW0_OD_CYC    =
        CNT_W'((LOW0_OD_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LOW1_STD_CYC   =
        CNT_W'((LOW1_STD_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LOW1_OD_CYC    =
        CNT_W'((LOW1_OD_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SAMPLE_STD_CYC = CNT_W'(SAMPLE_STD_NS / LCLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SAMPLE_OD_CYC  = CNT_W'(SAMPLE_OD_NS / LCLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] APU_CYC        =
        CNT_W'((APU_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS);

    // ------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h1,
        ST_WAIT_DATA = 4'h2,
        ST_WAIT_ACK  = 4'h4,
        ST_RUN       = 4'h8
    } swb_cmd_state_t;

    typedef enum logic [3:0] {
        LS_IDLE = 4'h1,
        LS_LOW  = 4'h2,
        LS_REL  = 4'h4,
        LS_SPU  = 4'h8
    } swb_link_state_t;

endpackage

// ==== pkg/swb_evt_if.sv ====
// event carrier between two clock domains
`timescale 1ns/10ps
interface swb_evt_if;
    logic src_evt;
    logic dst_evt;

    modport sender   (output src_evt);
    modport xfer     (input src_evt, output dst_evt);
    modport receiver (input dst_evt);
endinterface

// ==== verilog/swb_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/10ps
module swb_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule

// ==== verilog/swb_evt_xfer.sv ====
// toggle based single pulse crossing
`timescale 1ns/10ps
module swb_evt_xfer (
    // clocks and reset
    input  wire logic i_src_clk,
    input  wire logic i_dst_clk,
    input  wire logic i_rst_n,
    // event carrier
    swb_evt_if.xfer   evt
);
    logic src_tgl;
    logic dst_tgl;
    logic dst_prev;

    always_ff @(posedge i_src_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_tgl <= 1'b0;
        end else if (evt.src_evt) begin
            src_tgl <= ~src_tgl;
        end
    end

    swb_sync #(.W(1)) u_sync (
        .i_clk   (i_dst_clk),
        .i_rst_n (i_rst_n),
        .i_d     (src_tgl),
        .o_q     (dst_tgl)
    );

    always_ff @(posedge i_dst_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dst_prev <= 1'b0;
        end else begin
            dst_prev <= dst_tgl;
        end
    end

    assign evt.dst_evt = dst_tgl ^ dst_prev;
endmodule

// ==== verilog/swb_byte_cmd.sv ====
// byte write and byte read command engine with slot generator
`timescale 1ns/10ps
// Notes on behaviour
// R01 - code A5h plus one data byte sends that byte as eight write slots
// R02 - host issues byte commands only after line activity has ended
// R03 - write code while busy: code and data byte not acknowledged, command dropped
// R04 - write completes within eight slots plus 262.5ns after data LSB
// R05 - write slots start at most 262.5ns after data LSB falling edge
// R06 - slots go out LSB first, so wait for the whole data byte
// R07 - code 96h, no parameter, eight read slots stored in read data
// R08 - each read slot is a write-one slot
// R09 - read code while busy is not acknowledged and is ignored
// R10 - read completes within eight slots plus 262.5ns after code acknowledge
// R11 - first read slot starts at most 262.5ns after code acknowledge
// R12 - busy flag is 1 for eight slot periods, cleared when slots end
// R13 - accepting a byte command points the read pointer at status
// R14 - host sets read pointer to read data before fetching the byte
// R15 - write honours speed, strong and active pullup; read speed and active only
// R16 - first sampled bit lands in the least significant bit of read data
module swb_byte_cmd (
    // main clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    // link clock
    input  wire logic       i_lclk,
    // command from the host front end
    input  wire logic       i_cmd_valid,
    input  wire logic [7:0] i_cmd_code,
    output logic            o_cmd_ack,
    input  wire logic       i_data_valid,
    input  wire logic [7:0] i_data_byte,
    output logic            o_data_ack,
    input  wire logic       i_ack_fall,
    input  wire logic       i_xfer_stop,
    output logic            o_rptr_status,
    // configuration
    input  wire logic       i_overdrive_speed_select,
    input  wire logic       i_strong_pullup_enable,
    input  wire logic       i_active_pullup_enable,
    // status
    output logic            o_line_busy_flag,
    output logic [7:0]      o_read_data,
    // single wire line
    input  wire logic       i_line,
    output logic            o_line,
    output logic            o_line_oe
);
    import swb_pkg::*;

    // ------------------------------------------------------------
    // main domain state
    // ------------------------------------------------------------
    swb_cmd_state_t state;
    swb_cmd_state_t next_state;
    logic           line_busy_flag;
    logic [7:0]     cmd_byte;
    logic           cmd_read;
    logic           cfg_od;
    logic           cfg_spu;
    logic           cfg_apu;
    logic [7:0]     read_data;
    logic           code_write;
    logic           code_read;
    logic           cmd_take;
    logic           launch;
    logic           rptr_status;

    // ------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------
    swb_evt_if req_evt ();
    swb_evt_if done_evt ();

    swb_evt_xfer u_req_xfer (
        .i_src_clk (i_mclk),
        .i_dst_clk (i_lclk),
        .i_rst_n   (i_rst_n),
        .evt       (req_evt)
    );

    swb_evt_xfer u_done_xfer (
        .i_src_clk (i_lclk),
        .i_dst_clk (i_mclk),
        .i_rst_n   (i_rst_n),
        .evt       (done_evt)
    );

    // ------------------------------------------------------------
    // link domain state
    // ------------------------------------------------------------
    swb_link_state_t  lstate;
    swb_link_state_t  next_lstate;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] slot_cyc;
    logic [CNT_W-1:0] low_cyc;
    logic [CNT_W-1:0] sample_cyc;
    logic [2:0]       bit_idx;
    logic [7:0]       tx_shift;
    logic [7:0]       rx_shift;
    logic             l_read;
    logic             l_od;
    logic             l_spu;
    logic             l_apu;
    logic             line_s;
    logic             slot_end;
    logic             last_slot;
    logic             l_done;
    logic             next_line;
    logic             next_line_oe;

    // ------------------------------------------------------------
    // command decode and acknowledge
    // ------------------------------------------------------------
    assign code_write = (i_cmd_code == CMD_WRITE_BYTE);
    assign code_read  = (i_cmd_code == CMD_READ_BYTE);

    // a code is taken only while nothing is pending or running
    assign cmd_take = i_cmd_valid && (code_write || code_read)
                      && (state == ST_IDLE) && !line_busy_flag; // R03 R09

    assign o_cmd_ack = cmd_take; // R03 R09

    // a write code refused while running leaves the engine in ST_RUN, so the byte is refused too
    assign o_data_ack = i_data_valid && (state == ST_WAIT_DATA); // R03

    // write starts on the data LSB edge, read on the code acknowledge edge
    assign launch = ((state == ST_WAIT_DATA) && i_data_valid) // R05 R06
                    || ((state == ST_WAIT_ACK) && i_ack_fall); // R11

    assign req_evt.src_evt = launch;

    // ------------------------------------------------------------
    // main state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cmd_take && code_write) begin
                    next_state = ST_WAIT_DATA; // R01
                end else if (cmd_take) begin
                    next_state = ST_WAIT_ACK; // R07
                end
            end
            ST_WAIT_DATA: begin
                if (i_data_valid) begin
                    next_state = ST_RUN;
                end else if (i_xfer_stop) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WAIT_ACK: begin
                if (i_ack_fall) begin
                    next_state = ST_RUN;
                end else if (i_xfer_stop) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RUN: begin
                if (done_evt.dst_evt) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // busy flag
    // ------------------------------------------------------------
    // held from launch to the returned done event, i.e. eight slots plus crossing
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_busy_flag <= 1'b0;
        end else if (launch) begin
            line_busy_flag <= 1'b1; // R12
        end else if (done_evt.dst_evt) begin
            line_busy_flag <= 1'b0; // R12
        end
    end

    // ------------------------------------------------------------
    // command parameters, stable while the link runs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_byte <= BYTE_CLEAR;
            cmd_read <= 1'b0;
            cfg_od   <= 1'b0;
            cfg_spu  <= 1'b0;
            cfg_apu  <= 1'b0;
        end else if (launch) begin
            // read slots are write-one slots and never use strong pullup
            cmd_byte <= (state == ST_WAIT_ACK) ? ALL_ONES : i_data_byte; // R06 R08
            cmd_read <= (state == ST_WAIT_ACK);
            cfg_od   <= i_overdrive_speed_select; // R15
            cfg_spu  <= i_strong_pullup_enable && (state == ST_WAIT_DATA); // R15
            cfg_apu  <= i_active_pullup_enable; // R15
        end
    end

    // ------------------------------------------------------------
    // read data and read pointer
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            read_data <= BYTE_CLEAR;
        end else if (done_evt.dst_evt && cmd_read) begin
            read_data <= rx_shift; // R07
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rptr_status <= 1'b0;
        end else begin
            rptr_status <= cmd_take; // R13
        end
    end

    assign o_rptr_status    = rptr_status;
    assign o_line_busy_flag = line_busy_flag;
    assign o_read_data      = read_data;

    // ------------------------------------------------------------
    // link side: line input synchroniser
    // ------------------------------------------------------------
    swb_sync #(.W(1)) u_line_sync (
        .i_clk   (i_lclk),
        .i_rst_n (i_rst_n),
        .i_d     (i_line),
        .o_q     (line_s)
    );

    // ------------------------------------------------------------
    // link side: slot timing selection
    // ------------------------------------------------------------
    assign slot_cyc   = l_od ? SLOT_OD_CYC : SLOT_STD_CYC; // R15
    assign sample_cyc = l_od ? SAMPLE_OD_CYC : SAMPLE_STD_CYC;
    assign low_cyc    = tx_shift[0] ? (l_od ? LOW1_OD_CYC : LOW1_STD_CYC)
                                    : (l_od ? LOW0_OD_CYC : LOW0_STD_CYC);
    assign slot_end   = (cnt == slot_cyc - CNT_W'(1));
    assign last_slot  = (bit_idx == LAST_BIT);
    assign l_done     = (lstate == LS_REL) && slot_end && last_slot; // R04 R10

    assign done_evt.src_evt = l_done;

    // ------------------------------------------------------------
    // link side: slot state machine
    // ------------------------------------------------------------
    always_comb begin
        next_lstate = lstate;
        case (lstate)
            LS_IDLE: begin
                if (req_evt.dst_evt) begin
                    next_lstate = LS_LOW;
                end
            end
            LS_LOW: begin
                if (cnt == low_cyc - CNT_W'(1)) begin
                    next_lstate = LS_REL;
                end
            end
            LS_REL: begin
                if (slot_end && !last_slot) begin
                    next_lstate = LS_LOW;
                end else if (slot_end && l_spu) begin
                    next_lstate = LS_SPU; // R15
                end else if (slot_end) begin
                    next_lstate = LS_IDLE;
                end
            end
            LS_SPU: begin
                // strong pullup holds until the next command launches
                if (req_evt.dst_evt) begin
                    next_lstate = LS_LOW;
                end
            end
            default: begin
                next_lstate = LS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lstate <= LS_IDLE;
        end else begin
            lstate <= next_lstate;
        end
    end

    // ------------------------------------------------------------
    // link side: slot counter and bit index
    // ------------------------------------------------------------
    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt     <= '0;
            bit_idx <= 3'h0;
        end else if (req_evt.dst_evt) begin
            cnt     <= '0;
            bit_idx <= 3'h0;
        end else if ((lstate == LS_REL) && slot_end) begin
            cnt     <= '0;
            bit_idx <= bit_idx + 3'h1; // R01 R07
        end else if ((lstate == LS_LOW) || (lstate == LS_REL)) begin
            cnt     <= cnt + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // link side: parameter capture and shifters
    // ------------------------------------------------------------
    // main side holds these still from launch until done, so a plain capture is safe
    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_shift <= BYTE_CLEAR;
            l_read   <= 1'b0;
            l_od     <= 1'b0;
            l_spu    <= 1'b0;
            l_apu    <= 1'b0;
        end else if (req_evt.dst_evt) begin
            tx_shift <= cmd_byte;
            l_read   <= cmd_read;
            l_od     <= cfg_od;
            l_spu    <= cfg_spu;
            l_apu    <= cfg_apu;
        end else if ((lstate == LS_REL) && slot_end) begin
            tx_shift <= {1'b1, tx_shift[7:1]}; // R06
        end
    end

    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_shift <= BYTE_CLEAR;
        end else if ((lstate == LS_REL) && (cnt == sample_cyc)) begin
            rx_shift <= {line_s, rx_shift[7:1]}; // R16
        end
    end

    // ------------------------------------------------------------
    // link side: line drive
    // ------------------------------------------------------------
    // registered so the pin never glitches between states
    always_comb begin
        next_line    = 1'b1;
        next_line_oe = 1'b0;
        case (next_lstate)
            LS_LOW: begin
                next_line    = 1'b0;
                next_line_oe = 1'b1;
            end
            LS_REL: begin
                // active pullup briefly speeds the rising edge after release
                next_line_oe = l_apu && (cnt < low_cyc + APU_CYC); // R15
            end
            LS_SPU: begin
                next_line_oe = 1'b1; // R15
            end
            default: begin
                next_line_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_line    <= 1'b1;
            o_line_oe <= 1'b0;
        end else begin
            o_line    <= next_line;
            o_line_oe <= next_line_oe;
        end
    end

endmodule

// ==== verification/swb_byte_cmd_chk.sv ====
// port assertions for the byte command engine
`timescale 1ns/10ps
module swb_byte_cmd_chk (
    // clocks and reset
    input wire logic       i_mclk,
    input wire logic       i_rst_n,
    input wire logic       i_lclk,
    // command side
    input wire logic       i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic       o_cmd_ack,
    input wire logic       i_data_valid,
    input wire logic       o_data_ack,
    input wire logic       i_ack_fall,
    input wire logic       o_rptr_status,
    // status and line
    input wire logic       o_line_busy_flag,
    input wire logic       o_line,
    input wire logic       o_line_oe
);
    import swb_pkg::*;
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [15:0] busy_cnt;
    logic [9:0]  low_cnt;
    wire         low_drv = o_line_oe && !o_line;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) busy_cnt <= 16'h0000;
        else busy_cnt <= o_line_busy_flag ? busy_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge i_lclk or negedge i_rst_n) begin
        if (!i_rst_n) low_cnt <= 10'h000;
        else low_cnt <= low_drv ? low_cnt + 10'h001 : 10'h000;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_ack_ok; @(posedge i_mclk) disable iff (!i_rst_n) o_cmd_ack |-> i_cmd_valid &&
        !o_line_busy_flag && (i_cmd_code == CMD_WRITE_BYTE || i_cmd_code == CMD_READ_BYTE);
    endproperty
    a_ack_ok: assert property (p_ack_ok) else $error("bad code ack");
    property p_data_ack; @(posedge i_mclk) disable iff (!i_rst_n)
        o_data_ack |-> i_data_valid && !o_line_busy_flag;
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("bad data ack");
    property p_rptr; @(posedge i_mclk) disable iff (!i_rst_n) o_cmd_ack |=> o_rptr_status;
    endproperty
    a_rptr: assert property (p_rptr) else $error("no pointer pulse");
    property p_rptr_src; @(posedge i_mclk) disable iff (!i_rst_n)
        o_rptr_status |-> $past(o_cmd_ack);
    endproperty
    a_rptr_src: assert property (p_rptr_src) else $error("stray pointer pulse");
    property p_launch; @(posedge i_mclk) disable iff (!i_rst_n)
        i_data_valid && o_data_ack |=> o_line_busy_flag;
    endproperty
    a_launch: assert property (p_launch) else $error("write not launched");
    property p_busy_src; @(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_line_busy_flag) |-> $past(i_data_valid) || $past(i_ack_fall);
    endproperty
    a_busy_src: assert property (p_busy_src) else $error("busy without launch");
    property p_first_slot; @(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_line_busy_flag) |-> ##[1:20] low_drv;
    endproperty
    a_first_slot: assert property (p_first_slot) else $error("first slot late");
    property p_busy_len; @(posedge i_mclk) disable iff (!i_rst_n) $fell(o_line_busy_flag)
        |-> busy_cnt inside {[16'h07D0:16'h07EE], [16'h36B0:16'h36CE]};
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_low_len; @(posedge i_lclk) disable iff (!i_rst_n)
        $fell(low_drv) |-> low_cnt inside {10'h008, 10'h030, 10'h040, 10'h1E0};
    endproperty
    a_low_len: assert property (p_low_len) else $error("slot low time wrong");
endmodule
bind swb_byte_cmd swb_byte_cmd_chk u_chk (.i_mclk, .i_rst_n, .i_lclk, .i_cmd_valid, .i_cmd_code,
    .o_cmd_ack, .i_data_valid, .o_data_ack, .i_ack_fall, .o_rptr_status, .o_line_busy_flag,
    .o_line, .o_line_oe);

// ==== verification/swb_line_model.sv ====
// single wire responder: records write slots, answers read slots
`timescale 1ns/10ps
module swb_line_model (
    // line and mode
    input  wire logic       i_line,
    input  wire logic       i_od,
    input  wire logic [7:0] i_tx,
    // results
    output logic            o_pull,
    output logic [7:0]      o_rx
);
    logic [2:0] idx;
    initial begin
        o_pull = 1'b0;
        o_rx   = 8'h00;
        idx    = 3'h0;
    end
    // busy blocking keeps later edges of the same slot from opening a new one
    always @(negedge i_line) begin
        if (!o_pull) begin
            o_pull = !i_tx[idx];
            #(i_od ? 4000 : 30000);
            o_rx   = {i_line, o_rx[7:1]};
            o_pull = 1'b0;
            idx    = idx + 3'h1;
        end
    end
endmodule

// ==== verification/swb_byte_cmd_tb.sv ====
// self-checking bench for the byte command engine
`timescale 1ns/10ps
module swb_byte_cmd_tb;
    import swb_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       i_mclk, i_rst_n, i_lclk, i_cmd_valid, i_data_valid, i_ack_fall, i_xfer_stop;
    logic       i_overdrive_speed_select, i_strong_pullup_enable, i_active_pullup_enable;
    logic [7:0] i_cmd_code, i_data_byte, o_read_data, tx, rx;
    logic       o_cmd_ack, o_data_ack, o_rptr_status, o_line_busy_flag, o_line, o_line_oe, pull;
    int         mismatches, num_checks;
    // pull-up on the wire: released line reads high
    wire        i_line = !((o_line_oe && !o_line) || pull);
    swb_byte_cmd u_dut (.i_mclk, .i_rst_n, .i_lclk, .i_cmd_valid, .i_cmd_code, .o_cmd_ack,
        .i_data_valid, .i_data_byte, .o_data_ack, .i_ack_fall, .i_xfer_stop, .o_rptr_status,
        .i_overdrive_speed_select, .i_strong_pullup_enable, .i_active_pullup_enable,
        .o_line_busy_flag, .o_read_data, .i_line, .o_line, .o_line_oe);
    swb_line_model u_far (.i_line(i_line), .i_od(i_overdrive_speed_select), .i_tx(tx),
        .o_pull(pull), .o_rx(rx));
    initial begin
        i_mclk = 1'b0;
        forever #(MCLK_PERIOD_NS / 2) i_mclk = ~i_mclk;
    end
    initial begin
        i_lclk = 1'b0;
        #17;
        forever #62.5 i_lclk = ~i_lclk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ack is combinational, pointer pulse lands one edge later
    task automatic cmd(input logic [7:0] c, input logic ok);
        @(negedge i_mclk);
        i_cmd_valid = 1'b1;
        i_cmd_code  = c;
        #1 chk({7'h00, o_cmd_ack}, {7'h00, ok});
        @(negedge i_mclk);
        i_cmd_valid = 1'b0;
        chk({7'h00, o_rptr_status}, {7'h00, ok});
    endtask
    task automatic dat(input logic [7:0] b, input logic ok);
        @(negedge i_mclk);
        i_data_valid = 1'b1;
        i_data_byte  = b;
        #1 chk({7'h00, o_data_ack}, {7'h00, ok});
        @(negedge i_mclk);
        i_data_valid = 1'b0;
    endtask
    task automatic strobe(input logic af);
        @(negedge i_mclk);
        i_ack_fall  = af;
        i_xfer_stop = !af;
        @(negedge i_mclk);
        i_ack_fall  = 1'b0;
        i_xfer_stop = 1'b0;
    endtask
    // busy must be up now and fall after eight slots; lo in main clock cycles
    task automatic done(input int lo);
        int n;
        n = 0;
        chk({7'h00, o_line_busy_flag}, 8'h01);
        while (o_line_busy_flag === 1'b1 && n < lo + 40) begin
            @(negedge i_mclk);
            n++;
        end
        chk({7'h00, n >= lo - 10 && n <= lo + 30}, 8'h01);
        if (o_line_busy_flag !== 1'b0) close_out();
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {i_cmd_valid, i_data_valid, i_ack_fall, i_xfer_stop} = 4'h0;
        {i_strong_pullup_enable, i_active_pullup_enable} = 2'h0;
        i_overdrive_speed_select = 1'b1;
        i_cmd_code  = 8'h00;
        i_data_byte = 8'h00;
        tx          = 8'hFF;
        mismatches  = 0;
        num_checks  = 0;
        i_rst_n     = 1'b0;
        repeat (5) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (12) @(negedge i_mclk);
        cmd(8'h87, 1'b0);
        cmd(CMD_WRITE_BYTE, 1'b1);
        dat(8'h3C, 1'b1);
        cmd(CMD_READ_BYTE, 1'b0);
        cmd(CMD_WRITE_BYTE, 1'b0);
        dat(8'h55, 1'b0);
        done(2000);
        chk(rx, 8'h3C);
        chk(o_read_data, 8'h00);
        cmd(CMD_WRITE_BYTE, 1'b1);
        strobe(1'b0);
        dat(8'hFF, 1'b0);
        chk({7'h00, o_line_busy_flag}, 8'h00);
        i_active_pullup_enable = 1'b1;
        tx = 8'hA6;
        cmd(CMD_READ_BYTE, 1'b1);
        strobe(1'b1);
        done(2000);
        chk(o_read_data, 8'hA6);
        i_overdrive_speed_select = 1'b0;
        i_strong_pullup_enable = 1'b1;
        tx = 8'hFF;
        cmd(CMD_WRITE_BYTE, 1'b1);
        dat(8'hC3, 1'b1);
        done(14000);
        chk(rx, 8'hC3);
        chk({6'h00, o_line_oe, o_line}, 8'h03);
        tx = 8'h5A;
        cmd(CMD_READ_BYTE, 1'b1);
        strobe(1'b1);
        done(14000);
        chk(o_read_data, 8'h5A);
        close_out();
    end
endmodule
